// ---- verilog/ctm_pkg.sv ----
// Constants, carrier types and register map of the compact 10-bit timer.
// Behaviour
// - Pause holds counter value, resumes from it
// - Clock select picks one of seven count sources
// - On bit rising edge clears counter, runs
// - On bit low stops counter, keeps value
// - On rise restores initial pin level
// - Period value compares counter bits nine to seven
// - Period zero lets counter overflow at maximum
// - Mode field selects compare, PWM or timer
// - Compare A match acts on pin per field
// - PWM pin field forces inactive, active, waveform
// - Requested level equal to pin means no change
// - Initial level bit sets level or polarity
// - Invert bit inverts pin outside timer mode
// - Swap bit exchanges period and duty comparators
// - Clear source bit picks A or period match
// - Clear source bit ignored in PWM mode
// - Counter readable, compare A readable and writable
// - Timer mode leaves the pin undriven
// - Low bytes pass through one shared buffer
// - Clear source one suppresses period match flag
package ctm_pkg;

    localparam int CTM_AW = 5;
    localparam logic [CTM_AW-1:0] CTM_OFS_CTRL0 = 5'h00;
    localparam logic [CTM_AW-1:0] CTM_OFS_CTRL1 = 5'h04;
    localparam logic [CTM_AW-1:0] CTM_OFS_CNTL  = 5'h08;
    localparam logic [CTM_AW-1:0] CTM_OFS_CNTH  = 5'h0C;
    localparam logic [CTM_AW-1:0] CTM_OFS_CMPL  = 5'h10;
    localparam logic [CTM_AW-1:0] CTM_OFS_CMPH  = 5'h14;
    localparam logic [CTM_AW-1:0] CTM_OFS_FLAGS = 5'h18;

    // Field positions in the two control registers and the flag register.
    localparam int CTM_B_PAUSE = 7;
    localparam int CTM_B_CKSEL = 4;
    localparam int CTM_B_ON    = 3;
    localparam int CTM_B_MODE  = 6;
    localparam int CTM_B_PINF  = 4;
    localparam int CTM_B_INIT  = 3;
    localparam int CTM_B_INV   = 2;
    localparam int CTM_B_SWAP  = 1;
    localparam int CTM_B_CLR   = 0;
    localparam int CTM_B_FLAGA = 0;
    localparam int CTM_B_FLAGP = 1;

    localparam logic [7:0] CTM_RST_CTRL = 8'h00;
    localparam logic [9:0] CTM_RST_CMPA = 10'h000;
    localparam logic [9:0] CTM_CNT_MAX  = 10'h3FF;
    localparam logic [5:0] CTM_HDIV16   = 6'h0F;
    localparam logic [5:0] CTM_HDIV64   = 6'h3F;
    localparam logic [1:0] CTM_SDIV4    = 2'h3;

    localparam logic [1:0] CTM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CTM_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CTM_MODE_CMP   = 2'h0,
        CTM_MODE_UNDEF = 2'h1,
        CTM_MODE_PWM   = 2'h2,
        CTM_MODE_TIMER = 2'h3
    } ctm_mode_type;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } ctm_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } ctm_axi_rsp_type;

endpackage

// ---- verilog/ctm_timer.sv ----
// Compact 10-bit timer with AXI4-Lite register access and one output pin.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
module ctm_timer (
    input  wire logic                 aclk,           // System clock.
    input  wire logic                 aresetn,        // Sync reset, low.
    input  wire ctm_pkg::ctm_axi_req_type axi_req,    // Bus requests.
    output ctm_pkg::ctm_axi_rsp_type      axi_rsp,    // Bus answers.
    input  wire logic                 high_clk_tick,  // High clock strobe.
    input  wire logic                 sub_clk_tick,   // Sub clock strobe.
    input  wire logic                 external_count_input, // Count pin.
    output logic                      timer_output_pin, // Pin level.
    output logic                      timer_output_en   // Pin drive.
);
    import ctm_pkg::*;

    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    logic [9:0] cnt_q;
    logic [9:0] cnt_d;
    logic [9:0] cmpa_q;
    logic [7:0] lowbuf_q;
    logic       flag_a_q;
    logic       flag_p_q;
    logic       on_prev_q;
    logic       cmp_lvl_q;
    logic [1:0] sdiv_q;
    logic [5:0] hdiv_q;
    logic       ext_s1_q;
    logic       ext_s2_q;
    logic       ext_s3_q;
    logic       pin_q;
    logic       pin_en_q;

    // Control fields.
    logic       pause;
    logic [2:0] cksel;
    logic       timer_on;
    logic [2:0] period_compare;
    ctm_mode_type mode;
    logic [1:0] pinf;
    logic       init_lvl;
    logic       invert;
    logic       swap;
    logic       clr_sel;
    assign pause          = ctrl0_q[CTM_B_PAUSE];
    assign cksel          = ctrl0_q[CTM_B_CKSEL +: 3];
    assign timer_on       = ctrl0_q[CTM_B_ON];
    assign period_compare = ctrl0_q[2:0];
    assign mode           = ctm_mode_type'(ctrl1_q[CTM_B_MODE +: 2]);
    assign pinf           = ctrl1_q[CTM_B_PINF +: 2];
    assign init_lvl       = ctrl1_q[CTM_B_INIT];
    assign invert         = ctrl1_q[CTM_B_INV];
    assign swap           = ctrl1_q[CTM_B_SWAP];
    assign clr_sel        = ctrl1_q[CTM_B_CLR];

    // Bus handshake and decode.
    logic        aw_full_q;
    logic        w_full_q;
    logic [CTM_AW-1:0] waddr_q;
    logic        waddr_ok_q;
    logic [7:0]  wbyte_q;
    logic        wlane_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        aw_take;
    logic        w_take;
    logic        wr_go;
    logic        ar_take;
    logic [CTM_AW-1:0] raddr;
    logic        wr_hit;
    logic        rd_hit;
    logic        wr_en;
    assign aw_take = axi_req.awvalid & ~aw_full_q & ~bvalid_q;
    assign w_take  = axi_req.wvalid & ~w_full_q & ~bvalid_q;
    assign wr_go   = aw_full_q & w_full_q & ~bvalid_q;
    assign ar_take = axi_req.arvalid & ~rvalid_q;
    assign raddr   = axi_req.araddr[CTM_AW-1:0];
    assign wr_hit  = waddr_ok_q
                   & (waddr_q[1:0] == 2'h0) & (waddr_q <= CTM_OFS_FLAGS);
    assign rd_hit  = (axi_req.araddr[31:CTM_AW] == '0)
                   & (raddr[1:0] == 2'h0) & (raddr <= CTM_OFS_FLAGS);
    assign wr_en   = wr_go & wlane_q & wr_hit;

    assign axi_rsp.awready = ~aw_full_q & ~bvalid_q;
    assign axi_rsp.wready  = ~w_full_q & ~bvalid_q;
    assign axi_rsp.bvalid  = bvalid_q;
    assign axi_rsp.bresp   = bresp_q;
    assign axi_rsp.arready = ~rvalid_q;
    assign axi_rsp.rvalid  = rvalid_q;
    assign axi_rsp.rdata   = rdata_q;
    assign axi_rsp.rresp   = rresp_q;

    logic wr_c0;
    logic wr_c1;
    logic wr_al;
    logic wr_ah;
    logic wr_fl;
    logic rd_dh;
    logic rd_ah;
    assign wr_c0 = wr_en & (waddr_q == CTM_OFS_CTRL0);
    assign wr_c1 = wr_en & (waddr_q == CTM_OFS_CTRL1);
    assign wr_al = wr_en & (waddr_q == CTM_OFS_CMPL);
    assign wr_ah = wr_en & (waddr_q == CTM_OFS_CMPH);
    assign wr_fl = wr_en & (waddr_q == CTM_OFS_FLAGS);
    assign rd_dh = ar_take & rd_hit & (raddr == CTM_OFS_CNTH);
    assign rd_ah = ar_take & rd_hit & (raddr == CTM_OFS_CMPH);

    // Read data mux; low bytes come from the shared buffer.
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        unique case (raddr)
            CTM_OFS_CTRL0: rd_byte = ctrl0_q;
            CTM_OFS_CTRL1: rd_byte = ctrl1_q;
            CTM_OFS_CNTL:  rd_byte = lowbuf_q;
            CTM_OFS_CNTH:  rd_byte = {6'h00, cnt_q[9:8]};
            CTM_OFS_CMPL:  rd_byte = lowbuf_q;
            CTM_OFS_CMPH:  rd_byte = {6'h00, cmpa_q[9:8]};
            CTM_OFS_FLAGS: rd_byte = {6'h00, flag_p_q, flag_a_q};
            default:       rd_byte = 8'h00;
        endcase
    end

    // Write channel: address and data taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            waddr_q   <= '0;
            waddr_ok_q <= 1'b0;
            wbyte_q   <= 8'h00;
            wlane_q   <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= CTM_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full_q <= 1'b1;
                waddr_q   <= axi_req.awaddr[CTM_AW-1:0];
                waddr_ok_q <= (axi_req.awaddr[31:CTM_AW] == '0);
            end
            if (w_take) begin
                w_full_q <= 1'b1;
                wbyte_q  <= axi_req.wdata[7:0];
                wlane_q  <= axi_req.wstrb[0];
            end
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_hit ? CTM_RESP_OKAY : CTM_RESP_SLVERR;
            end else if (bvalid_q && axi_req.bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read channel: data registered one cycle after the address.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= CTM_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            rresp_q  <= rd_hit ? CTM_RESP_OKAY : CTM_RESP_SLVERR;
        end else if (rvalid_q && axi_req.rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Control registers and compare A with the low-byte buffer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl0_q  <= CTM_RST_CTRL;
            ctrl1_q  <= CTM_RST_CTRL;
            cmpa_q   <= CTM_RST_CMPA;
            lowbuf_q <= 8'h00;
        end else begin
            if (wr_c0) begin
                ctrl0_q <= wbyte_q;
            end
            if (wr_c1) begin
                ctrl1_q <= wbyte_q;
            end
            if (wr_ah) begin
                cmpa_q <= {wbyte_q[1:0], lowbuf_q};
            end
            if (wr_al) begin
                lowbuf_q <= wbyte_q;
            end else if (rd_dh) begin
                lowbuf_q <= cnt_q[7:0];
            end else if (rd_ah) begin
                lowbuf_q <= cmpa_q[7:0];
            end
        end
    end

    // External count pin synchroniser and edge detect after stage two.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= external_count_input;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // Prescalers for the divided system and high clocks.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sdiv_q <= 2'h0;
            hdiv_q <= 6'h00;
        end else begin
            sdiv_q <= sdiv_q + 2'h1;
            if (high_clk_tick) begin
                hdiv_q <= hdiv_q + 6'h01;
            end
        end
    end

    logic tick;
    always_comb begin
        unique case (cksel)
            3'h0: tick = (sdiv_q == CTM_SDIV4);
            3'h1: tick = 1'b1;
            3'h2: tick = high_clk_tick & (hdiv_q[3:0] == CTM_HDIV16[3:0]);
            3'h3: tick = high_clk_tick & (hdiv_q == CTM_HDIV64);
            3'h4: tick = sub_clk_tick;
            3'h5: tick = sub_clk_tick;
            3'h6: tick = ext_s2_q & ~ext_s3_q;
            3'h7: tick = ~ext_s2_q & ext_s3_q;
            default: tick = 1'b0;
        endcase
    end

    // Comparators look at the value the next tick would reach.
    logic [9:0]  cnt_inc;
    logic        on_rise;
    logic        run;
    logic        is_pwm;
    logic        p_match;
    logic        a_match;
    logic        clr_by_a;
    logic        p_flag_ok;
    assign cnt_inc = cnt_q + 10'h001;
    // Rising edge of the on bit.
    assign on_rise = timer_on & ~on_prev_q;
    // Count only when on and not paused.
    assign run     = timer_on & ~pause & tick & ~on_rise;
    assign is_pwm  = (mode == CTM_MODE_PWM);
    // Period match on bits 9..7, zero means overflow.
    assign p_match = (period_compare == 3'h0) ? (cnt_q == CTM_CNT_MAX)
                   : (cnt_inc == {period_compare, 7'h00});
    assign a_match = (cmpa_q != 10'h000) & (cnt_inc == cmpa_q);
    assign clr_by_a  = is_pwm ? swap : clr_sel;
    // Period flag suppressed when A clears outside PWM.
    assign p_flag_ok = is_pwm | ~clr_sel;

    // Next counter value with clear on the selected match.
    always_comb begin
        cnt_d = cnt_q;
        if (on_rise) begin
            cnt_d = 10'h000;
        end else if (run) begin
            if (clr_by_a ? a_match : p_match) begin
                cnt_d = 10'h000;
            end else begin
                cnt_d = cnt_inc;
            end
        end
    end

    // Counter, on-edge history and match flags; a set beats a clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q     <= 10'h000;
            on_prev_q <= 1'b0;
            flag_a_q  <= 1'b0;
            flag_p_q  <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            on_prev_q <= timer_on;
            flag_a_q  <= (run & a_match) |
                         (flag_a_q & ~(wr_fl & wbyte_q[CTM_B_FLAGA]));
            flag_p_q  <= (run & p_match & p_flag_ok) |
                         (flag_p_q & ~(wr_fl & wbyte_q[CTM_B_FLAGP]));
        end
    end

    // PWM duty: below duty the waveform is at its active level.
    logic [10:0] duty;
    logic        pwm_act;
    // Duty from A or from period value times 128.
    assign duty    = swap ? ((period_compare == 3'h0) ? 11'h400
                             : {1'b0, period_compare, 7'h00})
                          : {1'b0, cmpa_q};
    assign pwm_act = ({1'b0, cnt_q} < duty);

    // Compare-mode pin level.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_lvl_q <= 1'b0;
        end else if (on_rise) begin
            cmp_lvl_q <= init_lvl;
        end else if (run && a_match && mode == CTM_MODE_CMP) begin
            // Pin action; equal level gives no change.
            unique case (pinf)
                2'h0: cmp_lvl_q <= cmp_lvl_q;
                2'h1: cmp_lvl_q <= 1'b0;
                2'h2: cmp_lvl_q <= 1'b1;
                2'h3: cmp_lvl_q <= ~cmp_lvl_q;
            endcase
        end
    end

    // Pin level before inversion.
    logic lvl;
    always_comb begin
        lvl = cmp_lvl_q;
        if (is_pwm) begin
            // Forced or waveform, active level from init bit.
            unique case (pinf)
                2'h0: lvl = ~init_lvl;
                2'h1: lvl = init_lvl;
                2'h2: lvl = pwm_act ? init_lvl : ~init_lvl;
                2'h3: lvl = ~init_lvl;
            endcase
        end
    end

    // Registered pin and its drive enable.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_q    <= 1'b0;
            pin_en_q <= 1'b0;
        end else begin
            pin_q    <= lvl ^ invert;
            // Timer mode and undefined mode leave pin free.
            pin_en_q <= (mode == CTM_MODE_CMP) | is_pwm;
        end
    end

    assign timer_output_pin = pin_q;
    assign timer_output_en  = pin_en_q;

endmodule

// ---- tb/ctm_sva.sv ----
// Bus handshake and pin assertions for the compact timer.
module ctm_sva (
    input wire logic                     aclk,             // Clock.
    input wire logic                     aresetn,          // Reset, low.
    input wire ctm_pkg::ctm_axi_req_type axi_req,          // Requests.
    input wire ctm_pkg::ctm_axi_rsp_type axi_rsp,          // Answers.
    input wire logic                     timer_output_pin, // Pin level.
    input wire logic                     timer_output_en   // Pin drive.
);
    timeunit 1ns;
    timeprecision 1ps;
    import ctm_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_RD_NEXT: assert property (
        axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read answer late");
    AST_RD_HOLD: assert property (
        axi_rsp.rvalid && !axi_req.rready |=>
        axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read answer dropped");
    AST_RD_DONE: assert property (
        axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
        else $error("read answer repeated");
    AST_AR_BLOCK: assert property (
        axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("second read taken");
    AST_WR_LAT: assert property (
        axi_req.awvalid && axi_rsp.awready &&
        axi_req.wvalid && axi_rsp.wready |=>
        !axi_rsp.bvalid ##1 axi_rsp.bvalid)
        else $error("write answer timing");
    AST_WR_HOLD: assert property (
        axi_rsp.bvalid && !axi_req.bready |=>
        axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write answer dropped");
    AST_RD_UPPER: assert property (
        axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    AST_PIN_RESET: assert property (
        $rose(aresetn) |-> !timer_output_en && !timer_output_pin)
        else $error("pin active after reset");
endmodule

bind ctm_timer ctm_sva i_ctm_sva (
    .aclk(aclk),
    .aresetn(aresetn),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .timer_output_pin(timer_output_pin),
    .timer_output_en(timer_output_en)
);

// ---- tb/ctm_pin_model.sv ----
// Far-side model: count pulse source and a pulled-up output pin.
module ctm_pin_model (
    input  wire logic aclk,      // System clock.
    input  wire logic pin_in,    // Timer output level.
    input  wire logic pin_en,    // Timer output drive.
    output logic      count_pin, // Count pulses.
    output logic      pin_level  // Resolved pin.
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pin_level = pin_en ? pin_in : 1'b1;
    initial count_pin = 1'b0;
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge aclk);
            count_pin <= 1'b1;
            repeat (6) @(posedge aclk);
            count_pin <= 1'b0;
            repeat (5) @(posedge aclk);
        end
    endtask
endmodule

// ---- tb/compact_10bit_timer_ctrl_test.sv ----
// Self-checking bench: registers, counting, compare pin and PWM.
module compact_10bit_timer_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ctm_pkg::*;
    logic            aclk = 1'b0;
    logic            aresetn = 1'b0;
    logic            hi_tick = 1'b1;
    logic            sub_tick = 1'b1;
    logic            count_pin;
    logic            pin_level;
    logic            out_pin;
    logic            out_en;
    ctm_axi_req_type rq = '0;
    ctm_axi_rsp_type rs;
    logic [1:0]      lr;
    int              errors = 0;
    int              checks_done = 0;
    int              cyc = 0;

    always #2.5 aclk = ~aclk;

    // Sub clock strobe on every second system clock.
    always @(posedge aclk) sub_tick <= ~sub_tick;

    ctm_timer i_ctm_timer (.aclk(aclk), .aresetn(aresetn), .axi_req(rq),
        .axi_rsp(rs), .high_clk_tick(hi_tick), .sub_clk_tick(sub_tick),
        .external_count_input(count_pin), .timer_output_pin(out_pin),
        .timer_output_en(out_en));
    ctm_pin_model i_ctm_pin_model (.aclk(aclk), .pin_in(out_pin),
        .pin_en(out_en), .count_pin(count_pin), .pin_level(pin_level));

    // Cuts a hung run short.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("errors=%0d checks=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge aclk);
        rq.awaddr <= {27'h0, a};
        rq.wdata <= {24'h0, d};
        rq.wstrb <= 4'hF;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        rq.bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
        end while (!rs.bvalid);
        rq.bready <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge aclk);
        rq.araddr <= {27'h0, a};
        rq.arvalid <= 1'b1;
        rq.rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (rs.arready) rq.arvalid <= 1'b0;
        end while (!rs.rvalid);
        rq.rready <= 1'b0;
        d = rs.rdata;
        lr = rs.rresp;
    endtask

    // Reads the counter high byte first, then the buffered low byte.
    task automatic rc(output logic [9:0] v);
        logic [31:0] h, l;
        rd(CTM_OFS_CNTH, h);
        rd(CTM_OFS_CNTL, l);
        v = {h[1:0], l[7:0]};
    endtask

    function automatic int divf(int s);
        return (s == 0) ? 4 : (s == 2) ? 16 : (s == 3) ? 64
             : (s >= 4) ? 2 : 1;
    endfunction

    // Level after a compare A match: pin field, start level, inversion.
    function automatic logic cmp_lvl(logic [3:0] k);
        logic l;
        case (k[3:2])
            2'h0: l = k[1];
            2'h1: l = 1'b0;
            2'h2: l = 1'b1;
            default: l = !k[1];
        endcase
        return l ^ k[0];
    endfunction

    // Main sequence of scenarios.
    initial begin
        logic [31:0] d, h, hi;
        logic [9:0] v, w, a;
        int n, t0;
        int cnt[6], span[6];
        void'($urandom(32'h4D1C847A));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(5'(i * 4), d);
            chk(d, 32'h0);
        end
        rd(5'h1C, d);
        chk(32'(lr), 32'(CTM_RESP_SLVERR));
        a = 10'($urandom);
        wr(CTM_OFS_CMPL, a[7:0]);
        wr(CTM_OFS_CMPH, {6'h0, a[9:8]});
        rd(CTM_OFS_CMPH, h);
        rd(CTM_OFS_CMPL, d);
        chk({22'h0, h[1:0], d[7:0]}, {22'h0, a});
        wr(CTM_OFS_CTRL1, 8'hC0);
        // The bench's own cycle count between start and pause sets the
        // expected count for sources 0 to 5.
        for (int s = 0; s < 6; s++) begin
            wr(CTM_OFS_CTRL0, {1'b0, 3'(s), 4'h8});
            t0 = cyc;
            repeat (200) @(posedge aclk);
            wr(CTM_OFS_CTRL0, {1'b1, 3'(s), 4'h8});
            span[s] = cyc - t0;
            rc(v);
            repeat (20) @(posedge aclk);
            rc(w);
            chk(32'(w), 32'(v));
            wr(CTM_OFS_CTRL0, {1'b0, 3'(s), 4'h0});
            rc(w);
            chk(32'(w), 32'(v));
            cnt[s] = 32'(v);
        end
        for (int s = 0; s < 6; s++) begin
            n = span[s] / divf(s);
            chk(32'(cnt[s] >= n - 1 && cnt[s] <= n + 1), 32'h1);
        end
        wr(CTM_OFS_CTRL0, 8'h98);
        rc(v);
        chk(32'(v), 32'h0);
        wr(CTM_OFS_CTRL0, 8'h00);
        for (int s = 6; s < 8; s++) begin
            n = 1 + $urandom_range(7);
            wr(CTM_OFS_CTRL0, {1'b0, 3'(s), 4'h8});
            i_ctm_pin_model.pulses(n);
            repeat (8) @(posedge aclk);
            rc(v);
            chk(32'(v), 32'(n));
            wr(CTM_OFS_CTRL0, 8'h00);
        end
        wr(CTM_OFS_CMPL, 8'hE8);
        wr(CTM_OFS_CMPH, 8'h03);
        for (int k = 0; k < 16; k++) begin
            wr(CTM_OFS_CTRL1, {2'b00, 4'(k), 2'b01});
            wr(CTM_OFS_CTRL0, 8'h18);
            repeat (10) @(posedge aclk);
            chk(32'(pin_level), 32'(k[1] ^ k[0]));
            chk(32'(out_en), 32'h1);
            repeat (1100) @(posedge aclk);
            chk(32'(pin_level), 32'(cmp_lvl(4'(k))));
            wr(CTM_OFS_CTRL0, 8'h10);
        end
        wr(CTM_OFS_CTRL1, 8'hC0);
        wr(CTM_OFS_CTRL0, 8'h18);
        repeat (3) @(posedge aclk);
        chk(32'({out_en, pin_level}), 32'h1);
        wr(CTM_OFS_CTRL0, 8'h10);
        wr(CTM_OFS_CMPL, 8'h40);
        wr(CTM_OFS_CMPH, 8'h00);
        for (int j = 0; j < 4; j++) begin
            wr(CTM_OFS_CTRL1, {2'b10, 2'(j < 2 ? j : 2), 2'b10,
                j == 3, j == 2});
            wr(CTM_OFS_CTRL0, 8'h19);
            repeat (20) @(posedge aclk);
            hi = 32'h0;
            repeat (128) begin
                @(posedge aclk);
                hi += 32'(pin_level);
            end
            chk(hi, j == 0 ? 0 : j == 2 ? 64 : 128);
            wr(CTM_OFS_CTRL0, 8'h11);
        end
        wr(CTM_OFS_CTRL1, 8'h01);
        wr(CTM_OFS_CMPL, 8'h00);
        wr(CTM_OFS_CMPH, 8'h00);
        wr(CTM_OFS_FLAGS, 8'h03);
        wr(CTM_OFS_CTRL0, 8'h19);
        repeat (300) @(posedge aclk);
        rd(CTM_OFS_FLAGS, d);
        chk(d, 32'h0);
        wr(CTM_OFS_CTRL0, 8'h11);
        wr(CTM_OFS_CTRL1, 8'h00);
        wr(CTM_OFS_CTRL0, 8'h19);
        repeat (300) @(posedge aclk);
        rc(v);
        chk(32'(v[9:7]), 32'h0);
        rd(CTM_OFS_FLAGS, d);
        chk(d, 32'h2);
        wr(CTM_OFS_CTRL0, 8'h10);
        wr(CTM_OFS_FLAGS, 8'h03);
        wr(CTM_OFS_CTRL0, 8'h18);
        repeat (600) @(posedge aclk);
        rd(CTM_OFS_FLAGS, d);
        chk(d, 32'h0);
        repeat (500) @(posedge aclk);
        rd(CTM_OFS_FLAGS, d);
        chk(d, 32'h2);
        close_out();
    end
endmodule
